// ===== logic/standby_regs_pkg.sv
/*
  Shared constants for the standby-voltage, scratch and identification register bank:
  register byte offsets, field positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with 16-bit registers in the low half-word.
*/
package standby_regs_pkg;

  // Bus and register widths
  localparam int BUS_DATA_W = 32;
  localparam int REG_W = 16;
  localparam int STRB_W = BUS_DATA_W / 8;
  localparam int LANES = REG_W / 8;
  localparam int DEC_W = 4;

  // Register byte offsets within the decoded window
  localparam logic [3:0] OFS_STANDBY = 4'h0;
  localparam logic [3:0] OFS_SCRATCH0 = 4'h4;
  localparam logic [3:0] OFS_SCRATCH1 = 4'h8;
  localparam logic [3:0] OFS_CHIP_ID = 4'hC;

  // Standby voltage field: code in bits 7:0, bits 15:8 reserved
  localparam int STBY_CODE_W = 8;

  // Identification fields
  localparam int PART_ID_LSB = 0;
  localparam int SERIES_ID_LSB = 4;
  localparam int METAL_REV_LSB = 8;
  localparam int FULL_REV_LSB = 12;
  localparam int ID_FIELD_W = 4;
  localparam int REV_FIELD_W = 3;

  // Reset values
  localparam logic [REG_W-1:0] SCRATCH_RST = 16'h0000;
  localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
  localparam logic [BUS_DATA_W-REG_W-1:0] UPPER_ZERO = 16'h0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : standby_regs_pkg

// ===== logic/lane_merge_if.sv
/*
  Carrier between the register bank and its byte-lane merger.
  Assumes one register word is merged at a time, combinationally.
*/
`timescale 1ns/1ns
`default_nettype none

interface lane_merge_if;
  import standby_regs_pkg::*;
  logic [REG_W-1:0] old_word;
  logic [REG_W-1:0] new_word;
  logic [LANES-1:0] strb;
  logic [REG_W-1:0] merged;

  // Bank supplies operands, merger returns the result
  modport user (output old_word, output new_word, output strb, input merged);
  modport merger (input old_word, input new_word, input strb, output merged);
endinterface : lane_merge_if

`default_nettype wire

// ===== logic/byte_lane_merge.sv
/*
  Byte-lane merge of a bus write into a 16-bit register word.
  Assumes the strobes are already reduced to the register's own lanes.
*/
`timescale 1ns/1ns
`default_nettype none

module byte_lane_merge
  import standby_regs_pkg::*;
(
  lane_merge_if.merger port
);

  // Each lane takes new data only where its strobe is set
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign port.merged[g*8 +: 8] = port.strb[g] ? port.new_word[g*8 +: 8]
                                                : port.old_word[g*8 +: 8];
  end

endmodule : byte_lane_merge

`default_nettype wire

// ===== logic/standby_scratch_id_regs.sv
/*
  Register bank: core buck standby voltage code, two scratch words and a
  read-only identification word, behind an AXI4-Lite slave.
  Assumes a single clock aclk and a synchronous active-low reset aresetn;
  the fused default for the standby code is presented on otp_standby_code.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
// Contract
// - 8-bit read/write standby voltage code, all zeros to all ones monotonic
// - Standby code takes its default from fused memory whenever reset
// - Two independent 16-bit scratch words, read back unchanged, cleared at reset
// - Read-only 3-bit metal and full mask revisions, hardwired, not stored
// - Read-only 4-bit part and series identifiers with fixed codes
`timescale 1ns/1ns
`default_nettype none

module standby_scratch_id_regs
  import standby_regs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [3:0] PART_ID = 4'h5,    // Arbitrary value
  parameter logic [3:0] SERIES_ID = 4'h3,  // Arbitrary value
  parameter logic [2:0] METAL_REV = 3'h0,  // Arbitrary value
  parameter logic [2:0] FULL_REV = 3'h0    // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [BUS_DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [BUS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [STBY_CODE_W-1:0] otp_standby_code,
  output logic [STBY_CODE_W-1:0] core_buck_standby_voltage_code
);

  // The decode needs at least the four offset bits plus one bit above them
  if (ADDR_W <= DEC_W || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 32");
  end

  // Storage
  logic [STBY_CODE_W-1:0] stby_code_q;
  logic [REG_W-1:0] scratch_word_zero_q;
  logic [REG_W-1:0] scratch_word_one_q;

  // Write channel state; a ready flop low means its beat is held
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [REG_W-1:0] wdata_q;
  logic [LANES-1:0] wstrb_q;

  // Read channel state
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [BUS_DATA_W-1:0] rdata_q;

  // Handshakes
  wire logic aw_ok;
  wire logic w_ok;
  wire logic b_ok;
  wire logic ar_ok;
  wire logic r_ok;
  assign aw_ok = s_axi_awvalid & awready_q;
  assign w_ok = s_axi_wvalid & wready_q;
  assign b_ok = bvalid_q & s_axi_bready;
  assign ar_ok = s_axi_arvalid & arready_q;
  assign r_ok = rvalid_q & s_axi_rready;

  // Write fires once both beats are held and no response is pending
  wire logic write_go;
  assign write_go = ~awready_q & ~wready_q & ~bvalid_q;

  // Write address decode; anything above the four words is unmapped
  wire logic wr_in_window;
  wire logic wr_stby;
  wire logic wr_scr0;
  wire logic wr_scr1;
  wire logic wr_id;
  wire logic wr_mapped;
  assign wr_in_window = (awaddr_q >> DEC_W) == '0;
  assign wr_stby = wr_in_window & (awaddr_q[DEC_W-1:0] == OFS_STANDBY);
  assign wr_scr0 = wr_in_window & (awaddr_q[DEC_W-1:0] == OFS_SCRATCH0);
  assign wr_scr1 = wr_in_window & (awaddr_q[DEC_W-1:0] == OFS_SCRATCH1);
  assign wr_id = wr_in_window & (awaddr_q[DEC_W-1:0] == OFS_CHIP_ID);
  assign wr_mapped = wr_stby | wr_scr0 | wr_scr1 | wr_id;

  // Read address decode straight off the bus, taken on ar_ok
  wire logic rd_in_window;
  wire logic rd_stby;
  wire logic rd_scr0;
  wire logic rd_scr1;
  wire logic rd_id;
  wire logic rd_mapped;
  assign rd_in_window = (s_axi_araddr >> DEC_W) == '0;
  assign rd_stby = rd_in_window & (s_axi_araddr[DEC_W-1:0] == OFS_STANDBY);
  assign rd_scr0 = rd_in_window & (s_axi_araddr[DEC_W-1:0] == OFS_SCRATCH0);
  assign rd_scr1 = rd_in_window & (s_axi_araddr[DEC_W-1:0] == OFS_SCRATCH1);
  assign rd_id = rd_in_window & (s_axi_araddr[DEC_W-1:0] == OFS_CHIP_ID);
  assign rd_mapped = rd_stby | rd_scr0 | rd_scr1 | rd_id;

  // Identification word from constants only, so no write can alter it
  wire logic [REG_W-1:0] id_word;
  assign id_word = REG_ZERO
                 | (REG_W'(PART_ID) << PART_ID_LSB)
                 | (REG_W'(SERIES_ID) << SERIES_ID_LSB)
                 | (REG_W'(METAL_REV) << METAL_REV_LSB)
                 | (REG_W'(FULL_REV) << FULL_REV_LSB);

  // Standby register seen as a full word, upper byte reserved as zero
  wire logic [REG_W-1:0] stby_word;
  assign stby_word = {REG_ZERO[REG_W-1:STBY_CODE_W], stby_code_q};

  // Old value of the addressed word, fed to the lane merger
  wire logic [REG_W-1:0] wr_old;
  assign wr_old = wr_stby ? stby_word :
                  wr_scr0 ? scratch_word_zero_q :
                  wr_scr1 ? scratch_word_one_q : REG_ZERO;

  lane_merge_if mrg ();
  assign mrg.old_word = wr_old;
  assign mrg.new_word = wdata_q;
  assign mrg.strb = wstrb_q;

  byte_lane_merge u_merge (
    .port(mrg.merger)
  );

  // Read data selection
  wire logic [REG_W-1:0] rd_word;
  assign rd_word = rd_stby ? stby_word :
                   rd_scr0 ? scratch_word_zero_q :
                   rd_scr1 ? scratch_word_one_q :
                   rd_id ? id_word : REG_ZERO;

  // Write address beat; awready drops while the address is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
    end else if (aw_ok) begin
      awready_q <= 1'b0;
    end else if (write_go) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
    end else if (aw_ok) begin
      awaddr_q <= s_axi_awaddr;
    end
  end

  // Write data beat, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
    end else if (w_ok) begin
      wready_q <= 1'b0;
    end else if (write_go) begin
      wready_q <= 1'b1;
    end
  end

  // Upper bus lanes carry nothing, so only the low strobes are kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q <= REG_ZERO;
      wstrb_q <= '0;
    end else if (w_ok) begin
      wdata_q <= s_axi_wdata[REG_W-1:0];
      wstrb_q <= s_axi_wstrb[LANES-1:0];
    end
  end

  // Write response; unmapped addresses answer SLVERR, id writes OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (write_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_ok) begin
      bvalid_q <= 1'b0;
    end
  end

  // Standby code: fused default on every reset, reserved byte dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stby_code_q <= otp_standby_code;
    end else if (write_go && wr_stby) begin
      stby_code_q <= mrg.merged[STBY_CODE_W-1:0];
    end
  end

  // Scratch words, each written only at its own address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_word_zero_q <= SCRATCH_RST;
      scratch_word_one_q <= SCRATCH_RST;
    end else begin
      if (write_go && wr_scr0) begin
        scratch_word_zero_q <= mrg.merged;
      end
      if (write_go && wr_scr1) begin
        scratch_word_one_q <= mrg.merged;
      end
    end
  end

  // Read channel: one request in flight, answer one cycle after the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else if (ar_ok) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
    end else if (r_ok) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Upper half-word always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_ok) begin
      rdata_q <= {UPPER_ZERO, rd_word};
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Port drive, all from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign core_buck_standby_voltage_code = stby_code_q;

  // Checks

  a_stby_fused_default: assert property (@(posedge aclk)
    !aresetn |=> stby_code_q == $past(otp_standby_code))
    else $error("standby code not loaded from fused default at reset");

  a_stby_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    write_go && wr_stby && wstrb_q[0] |=> stby_code_q == $past(wdata_q[STBY_CODE_W-1:0]))
    else $error("standby code write did not land");

  a_stby_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_ok && rd_stby |=> rdata_q == {24'h00_0000, $past(stby_code_q)})
    else $error("standby code readback mismatch or reserved bits set");

  a_scratch_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> scratch_word_zero_q == SCRATCH_RST && scratch_word_one_q == SCRATCH_RST)
    else $error("scratch words not cleared by reset");

  a_scratch_independent: assert property (@(posedge aclk) disable iff (!aresetn)
    write_go && wr_scr0 |=> $stable(scratch_word_one_q))
    else $error("scratch one disturbed by write to scratch zero");

  a_scratch_full_write: assert property (@(posedge aclk) disable iff (!aresetn)
    write_go && wr_scr1 && (&wstrb_q) |=> scratch_word_one_q == $past(wdata_q))
    else $error("scratch one full write not stored");

  a_rev_fields_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_ok && rd_id |=> rdata_q[METAL_REV_LSB +: REV_FIELD_W] == METAL_REV
      && rdata_q[FULL_REV_LSB +: REV_FIELD_W] == FULL_REV)
    else $error("mask revision fields wrong");

  a_id_fields_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_ok && rd_id |=> rdata_q[PART_ID_LSB +: ID_FIELD_W] == PART_ID
      && rdata_q[SERIES_ID_LSB +: ID_FIELD_W] == SERIES_ID)
    else $error("identifier fields wrong");

  a_id_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    write_go && wr_id |=> $stable(stby_code_q) && $stable(scratch_word_zero_q)
      && $stable(scratch_word_one_q) && bresp_q == RESP_OKAY)
    else $error("identification write changed state");

  a_upper_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> rdata_q[BUS_DATA_W-1:REG_W] == UPPER_ZERO)
    else $error("upper half-word not zero");

  a_read_held: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && !s_axi_rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read answer dropped before rready");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    write_go |=> bvalid_q && awready_q && wready_q)
    else $error("write response missing after write");

endmodule : standby_scratch_id_regs

`default_nettype wire

// ===== dv/tb.sv
/*
  Self-checking bench for the standby code, scratch and identification register bank.
  Assumes the bank answers AXI4-Lite on aclk and resets synchronously on aresetn.
*/
`timescale 1ns/1ns
`default_nettype none

// Compare and count; case inequality so an unknown never passes
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module tb
  import standby_regs_pkg::*;
;
  localparam logic [3:0] PART_V = 4'h9;    // Arbitrary value
  localparam logic [3:0] SERIES_V = 4'h2;  // Arbitrary value
  localparam logic [2:0] METAL_V = 3'h5;   // Arbitrary value
  localparam logic [2:0] FULL_V = 3'h3;    // Arbitrary value
  localparam logic [REG_W-1:0] ID_EXP = REG_W'((int'(PART_V) << PART_ID_LSB) |
    (int'(SERIES_V) << SERIES_ID_LSB) | (int'(METAL_V) << METAL_REV_LSB) |
    (int'(FULL_V) << FULL_REV_LSB));

  typedef struct {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [1:0] br;
    logic [7:0] ra;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] code;
  } row_t;

  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, otp_standby_code, core_buck_standby_voltage_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] prot_zero;
  int failures, n_checks;

  // Write then read back; starts from fuse code A5 and cleared scratch words
  row_t rows [11] = '{
    '{8'h04, 32'hFFFF_1234, 4'hF, RESP_OKAY, 8'h04, 32'h0000_1234, RESP_OKAY, 8'hA5},
    '{8'h08, 32'h0000_ABCD, 4'h3, RESP_OKAY, 8'h04, 32'h0000_1234, RESP_OKAY, 8'hA5},
    '{8'h08, 32'h0000_5678, 4'h1, RESP_OKAY, 8'h08, 32'h0000_AB78, RESP_OKAY, 8'hA5},
    '{8'h04, 32'h0000_0000, 4'h2, RESP_OKAY, 8'h04, 32'h0000_0034, RESP_OKAY, 8'hA5},
    '{8'h00, 32'h0000_FF00, 4'h3, RESP_OKAY, 8'h00, 32'h0000_0000, RESP_OKAY, 8'h00},
    '{8'h00, 32'h0000_00FF, 4'h1, RESP_OKAY, 8'h00, 32'h0000_00FF, RESP_OKAY, 8'hFF},
    '{8'h00, 32'h0000_0080, 4'h2, RESP_OKAY, 8'h00, 32'h0000_00FF, RESP_OKAY, 8'hFF},
    '{8'h0C, 32'h0000_FFFF, 4'h3, RESP_OKAY, 8'h0C, {16'h0000, ID_EXP}, RESP_OKAY, 8'hFF},
    '{8'h10, 32'h0000_1111, 4'h3, RESP_SLVERR, 8'h10, 32'h0000_0000, RESP_SLVERR, 8'hFF},
    '{8'h84, 32'h0000_2222, 4'h3, RESP_SLVERR, 8'h84, 32'h0000_0000, RESP_SLVERR, 8'hFF},
    '{8'h04, 32'hFFFF_0000, 4'hC, RESP_OKAY, 8'h04, 32'h0000_0034, RESP_OKAY, 8'hFF}
  };

  standby_scratch_id_regs #(.PART_ID(PART_V), .SERIES_ID(SERIES_V), .METAL_REV(METAL_V),
    .FULL_REV(FULL_V)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(prot_zero), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(prot_zero), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .otp_standby_code(otp_standby_code),
    .core_buck_standby_voltage_code(core_buck_standby_voltage_code)
  );

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Address may lag data by aw_lag cycles; each valid drops once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input int aw_lag, output logic [1:0] r);
    bit aw_done = 0;
    bit w_done = 0;
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_awvalid <= (aw_lag == 0);
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) aw_done = 1;
      if (s_axi_wvalid && s_axi_wready) w_done = 1;
      s_axi_awvalid <= !aw_done && (n >= aw_lag);
      s_axi_wvalid <= !w_done;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // Leading edge wait keeps the previous release and a new raise apart
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic do_reset(input logic [7:0] fuse);
    @(posedge aclk);
    otp_standby_code <= fuse;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // Every register after any reset: fused code, cleared scratch, fixed identity
  task automatic check_after_reset(input logic [7:0] fuse);
    axi_read(8'h00, data, resp);
    `CHK(data, {24'h00_0000, fuse})
    `CHK(core_buck_standby_voltage_code, fuse)
    axi_read(8'h04, data, resp);
    `CHK(data, 32'h0000_0000)
    axi_read(8'h08, data, resp);
    `CHK(data, 32'h0000_0000)
    axi_read(8'h0C, data, resp);
    `CHK(data, {UPPER_ZERO, ID_EXP})
    `CHK(resp, RESP_OKAY)
  endtask : check_after_reset

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: reset defaults first, then the table, then the awkward cases
  initial begin
    aresetn = 1'b0;
    otp_standby_code = 8'hA5;
    prot_zero = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    do_reset(8'hA5);
    check_after_reset(8'hA5);
    $display("test reset_defaults done");
    foreach (rows[i]) begin
      axi_write(rows[i].wa, rows[i].wd, rows[i].ws, 0, resp);
      `CHK(resp, rows[i].br)
      axi_read(rows[i].ra, data, resp);
      `CHK(data, rows[i].rd)
      `CHK(resp, rows[i].rr)
      `CHK(core_buck_standby_voltage_code, rows[i].code)
    end
    $display("test table done");
    // Data offered three cycles ahead of its address
    axi_write(8'h08, 32'h0000_5A5A, 4'h3, 3, resp);
    `CHK(resp, RESP_OKAY)
    axi_read(8'h08, data, resp);
    `CHK(data, 32'h0000_5A5A)
    $display("test data_first done");
    // Second reset mid-run must reload a changed fuse value
    axi_write(8'h00, 32'h0000_0011, 4'h1, 0, resp);
    `CHK(core_buck_standby_voltage_code, 8'h11)
    do_reset(8'h3C);
    check_after_reset(8'h3C);
    $display("test mid_run_reset done");
    end_of_test();
  end

  // Whole run is under two hundred cycles; generous margin before giving up
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
